// >>> modem_card_end.sv
`timescale 1ns/1ps
`default_nettype none

module modem_card_end
	import modem_seq_pkg::*;
#(
	parameter int unsigned TICK_CYC    = TICK_CYCLES,
	parameter ms_t         INIT_TIME   = INIT_MS,
	parameter ms_t         SAVE_TIME   = SAVE_MS
) (
	input  wire logic     core_clk,
	input  wire logic     rst,
	modem_ctrl_if.device  bus,
	input  wire logic     core_dump,
	input  wire logic     pcie_present,
	input  wire logic     usb_present,
	input  wire logic     wake_req,
	input  wire logic     need_refclk,
	input  wire logic     l1_exit_req,
	output logic          internal_power_unit_on,
	output logic          card_in_reset,
	output logic          pcie_in_reset,
	output logic          init_done,
	output logic          link_up,
	output logic          pcie_en,
	output logic          usb_en,
	output logic          in_l2
);

	// ********************************
	// Line decode and tick
	// ********************************
	logic       tick;
	logic       pwr_req;
	logic       restart_low;
	logic       hold_low;
	logic       long_restart;
	logic       dump_reset;
	dev_state_t state_ff;
	ms_t        ms_ff;
	ms_t        rst_lo_ff;
	ms_t        lnk_ms_ff;
	logic       link_up_ff;
	logic       l2_ff;
	logic       wake_ff;
	logic       refclk_request_n_ff;
	logic       ack_ff;
	logic       usb_en_ff;
	logic       pcie_en_ff;
	logic       reset_out_ff;
	logic       pcie_rst_ff;
	logic       powered;

	ms_tick #(.CYCLES(TICK_CYC)) u_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tick)
	);

	assign pwr_req     = bus.card_power_off_n;
	assign restart_low = !bus.restart_n;
	assign hold_low    = !bus.link_hold_n;
	// Strictly more than the minimum hold returns the card to its start
	assign long_restart = restart_low && (rst_lo_ff > RST_HOLD_MIN_MS);
	assign dump_reset   = core_dump && hold_low;
	assign powered = (state_ff == DEV_INIT) || (state_ff == DEV_RUN) ||
		(state_ff == DEV_SAVE) || (state_ff == DEV_RESET);

	// ********************************
	// Restart low-time counter
	// ********************************
	// Saturates so a very long hold cannot wrap back to short
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rst_lo_ff <= '0;
		end else if (!restart_low) begin
			rst_lo_ff <= '0;
		end else if (tick && (rst_lo_ff != '1)) begin
			rst_lo_ff <= rst_lo_ff + 1'b1;
		end
	end

	// ********************************
	// Card power state machine
	// ********************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= DEV_OFF;
			ms_ff    <= '0;
		end else if (!pwr_req) begin
			// Hardware power-off wins over every other activity
			state_ff <= DEV_OFF;
			ms_ff    <= '0;
		end else begin
			case (state_ff)
				DEV_OFF: begin
					state_ff <= DEV_INIT;
					ms_ff    <= '0;
				end
				DEV_INIT: begin
					if (long_restart || dump_reset) begin
						state_ff <= DEV_RESET;
					end else if (tick) begin
						if (ms_ff == INIT_TIME - 14'h0001) begin
							state_ff <= DEV_RUN;
						end
						ms_ff <= ms_ff + 1'b1;
					end
				end
				DEV_RUN: begin
					if (long_restart || dump_reset) begin
						state_ff <= DEV_RESET;
					end else if (bus.sd_req) begin
						state_ff <= DEV_SAVE;
						ms_ff    <= '0;
					end
				end
				DEV_SAVE: begin
					// Parameters saved and memory cleared before supply drops
					if (tick) begin
						if (ms_ff == SAVE_TIME - 14'h0001) begin
							state_ff <= DEV_DOWN;
						end
						ms_ff <= ms_ff + 1'b1;
					end
				end
				DEV_DOWN: begin
					// Only the power-off line brings the card out of here
					state_ff <= DEV_DOWN;
				end
				DEV_RESET: begin
					// Supply stays on; restart from scratch on release
					if (!restart_low && !dump_reset) begin
						state_ff <= DEV_INIT;
						ms_ff    <= '0;
					end
				end
				default: begin
					state_ff <= DEV_OFF;
					ms_ff    <= '0;
				end
			endcase
		end
	end

	// ********************************
	// PCIe link detection
	// ********************************
	// Counting ends one tick early so the link is up inside the window
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lnk_ms_ff  <= '0;
			link_up_ff <= 1'b0;
		end else if (hold_low || !pcie_present || !powered || restart_low) begin
			lnk_ms_ff  <= '0;
			link_up_ff <= 1'b0;
		end else if (tick && !link_up_ff) begin
			lnk_ms_ff <= lnk_ms_ff + 1'b1;
			if (lnk_ms_ff == LINK_DET_MS - 14'h0002) begin
				link_up_ff <= 1'b1;
			end
		end
	end

	// ********************************
	// Low-power link state and wake
	// ********************************
	// L2 is entered when the host holds the link while the card runs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			l2_ff   <= 1'b0;
			wake_ff <= 1'b0;
		end else if (!hold_low || (state_ff != DEV_RUN)) begin
			// Host released link-hold: back towards L0
			l2_ff   <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			if (link_up_ff && !core_dump) begin
				l2_ff <= 1'b1;
			end
			if (l2_ff && wake_req) begin
				wake_ff <= 1'b1;
			end
		end
	end

	// ********************************
	// Clock request, ack and port enables
	// ********************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			refclk_request_n_ff    <= 1'b0;
			ack_ff       <= 1'b0;
			usb_en_ff    <= 1'b0;
			pcie_en_ff   <= 1'b0;
			reset_out_ff <= 1'b1;
			pcie_rst_ff  <= 1'b1;
		end else begin
			// Frozen while in L2 so the line does not toggle there
			if (!l2_ff) begin
				refclk_request_n_ff <= powered && (need_refclk || l1_exit_req);
			end
			ack_ff       <= (state_ff == DEV_DOWN);
			pcie_en_ff   <= powered && pcie_present;
			// PCIe wins when both hosts are attached
			usb_en_ff    <= (state_ff == DEV_RUN) && usb_present && !pcie_present;
			reset_out_ff <= restart_low || !powered || (state_ff == DEV_RESET);
			pcie_rst_ff  <= hold_low || !powered;
		end
	end

	assign bus.dev_refclk_request_n_oe = refclk_request_n_ff;
	assign bus.dev_wake_oe   = wake_ff;
	assign bus.sd_ack        = ack_ff;

	// ********************************
	// User-side status
	// ********************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			internal_power_unit_on <= 1'b0;
			init_done              <= 1'b0;
		end else begin
			internal_power_unit_on <= powered;
			init_done              <= (state_ff == DEV_RUN);
		end
	end

	assign card_in_reset = reset_out_ff;
	assign pcie_in_reset = pcie_rst_ff;
	assign link_up       = link_up_ff;
	assign pcie_en       = pcie_en_ff;
	assign usb_en        = usb_en_ff;
	assign in_l2         = l2_ff;
endmodule

`default_nettype wire

// >>> modem_seq_pkg.sv
package modem_seq_pkg;

	// ********************************
	// Clock and millisecond tick
	// ********************************
	localparam int unsigned CLK_PERIOD_NS  = 25;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	// Tick period is a least time, so the cycle count rounds up
	localparam int unsigned TICK_CYCLES    =
		(TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ********************************
	// Delays in milliseconds (tick counts)
	// ********************************
	typedef logic [13:0] ms_t;
	localparam ms_t INIT_MS        = 14'h2710; // 10 s initialisation
	localparam ms_t SAVE_MS        = 14'h0064; // Parameter save and memory clear
	localparam ms_t RST_REL_MIN_MS = 14'h0008;
	localparam ms_t RST_REL_REC_MS = 14'h0014;
	localparam ms_t HOLD_REL_MIN_MS = 14'h0032;
	localparam ms_t HOLD_REL_REC_MS = 14'h0064;
	localparam ms_t LINK_DET_MS    = 14'h002D;
	localparam ms_t SD_TIMEOUT_MS  = 14'h1388; // 5 s
	localparam ms_t OFF1_MIN_MS    = 14'h0010;
	localparam ms_t OFF1_REC_MS    = 14'h0014;
	localparam ms_t OFF2_MIN_MS    = 14'h0002;
	localparam ms_t OFF2_REC_MS    = 14'h000A;
	localparam ms_t RST_HOLD_MIN_MS = 14'h0002;
	localparam ms_t RST_HOLD_REC_MS = 14'h000A;
	localparam ms_t OFF_HOLD_MS    = 14'h01F4; // 500 ms discharge

	// ********************************
	// State machines
	// ********************************
	typedef enum logic [2:0] {
		DEV_OFF, DEV_INIT, DEV_RUN, DEV_SAVE, DEV_DOWN, DEV_RESET
	} dev_state_t;

	typedef enum logic [3:0] {
		H_OFF, H_UP_RST, H_UP_HOLD, H_LINK, H_ON, H_SD_WAIT,
		H_DN_HOLD, H_DN_RST, H_OFF_MIN, H_WRST, H_L2
	} host_state_t;

endpackage

// >>> modem_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface modem_ctrl_if;
	// ********************************
	// Driver side of each line
	// ********************************
	logic pwr_off_o;
	logic pwr_off_oe;
	logic restart_o;
	logic restart_oe;
	logic hold_o;
	logic hold_oe;
	logic host_refclk_request_n_oe;
	logic dev_refclk_request_n_oe;
	logic dev_wake_oe;
	logic sd_req;
	logic sd_ack;

	// ********************************
	// Resolved line levels
	// ********************************
	// Every line has a pull-up, so an undriven line reads high
	logic card_power_off_n;
	logic restart_n;
	logic link_hold_n;
	logic refclk_request_n;
	logic link_wake_n;

	assign card_power_off_n = pwr_off_oe ? pwr_off_o : 1'b1;
	assign restart_n        = restart_oe ? restart_o : 1'b1;
	assign link_hold_n      = hold_oe ? hold_o : 1'b1;
	assign refclk_request_n = !(host_refclk_request_n_oe || dev_refclk_request_n_oe);
	assign link_wake_n      = !dev_wake_oe;

	modport device (
		input  card_power_off_n, restart_n, link_hold_n, refclk_request_n,
		input  sd_req,
		output dev_refclk_request_n_oe, dev_wake_oe, sd_ack,
		input  link_wake_n
	);

	modport host (
		output pwr_off_o, pwr_off_oe, restart_o, restart_oe, hold_o, hold_oe,
		output host_refclk_request_n_oe, sd_req,
		input  sd_ack, link_wake_n, refclk_request_n, card_power_off_n
	);
endinterface

`default_nettype wire

// >>> ms_tick.sv
`timescale 1ns/1ps
`default_nettype none

module ms_tick
	import modem_seq_pkg::*;
#(
	parameter int unsigned CYCLES = TICK_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rst,
	output logic      tick
);
	localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_ff;
	logic         tick_ff;

	// ********************************
	// Free-running divider
	// ********************************
	// One pulse per period; every delay in the block is counted in these
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
			tick_ff <= (cnt_ff == LAST);
		end
	end

	assign tick = tick_ff;
endmodule

`default_nettype wire

// >>> modem_host_end.sv
`timescale 1ns/1ps
`default_nettype none

module modem_host_end
	import modem_seq_pkg::*;
#(
	parameter int unsigned TICK_CYC  = TICK_CYCLES,
	parameter ms_t         SD_WAIT   = SD_TIMEOUT_MS,
	parameter ms_t         OFF_HOLD  = OFF_HOLD_MS
) (
	input  wire logic    core_clk,
	input  wire logic    rst,
	modem_ctrl_if.host   bus,
	input  wire logic    cmd_power_on,
	input  wire logic    cmd_shutdown,
	input  wire logic    cmd_hw_off,
	input  wire logic    cmd_warm_reset,
	input  wire logic    cmd_full_reset,
	input  wire logic    cmd_enter_l2,
	input  wire logic    cmd_exit_l2,
	input  wire logic    want_refclk,
	input  wire logic    l2_refclk_request_n_on,
	input  wire logic    hold_connected,
	output logic         busy,
	output logic         card_on,
	output logic         card_in_l2,
	output logic         sd_timed_out
);

	logic        tick;
	host_state_t state_ff;
	ms_t         ms_ff;
	logic        full_ff;
	logic        pwr_ff;
	logic        rst_rel_ff;
	logic        hold_rel_ff;
	logic        hold_oe_ff;
	logic        l2_req_ff;
	logic        refclk_request_n_ff;
	logic        sd_ff;
	logic        tmo_ff;

	ms_tick #(.CYCLES(TICK_CYC)) u_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tick)
	);

	// ********************************
	// Host control sequencer
	// ********************************
	// Recommended delays are used; each is at least its minimum
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff    <= H_OFF;
			ms_ff       <= '0;
			full_ff     <= 1'b0;
			pwr_ff      <= 1'b0;
			rst_rel_ff  <= 1'b0;
			hold_rel_ff <= 1'b0;
			sd_ff       <= 1'b0;
			tmo_ff      <= 1'b0;
		end else begin
			if (tick) begin
				ms_ff <= ms_ff + 1'b1;
			end
			case (state_ff)
				H_OFF: begin
					if (cmd_power_on) begin
						pwr_ff   <= 1'b1;
						ms_ff    <= '0;
						state_ff <= H_UP_RST;
					end
				end
				H_UP_RST: begin
					if (tick && (ms_ff == RST_REL_REC_MS - 14'h0001)) begin
						rst_rel_ff <= 1'b1;
						state_ff   <= H_UP_HOLD;
					end
				end
				H_UP_HOLD: begin
					// Counter keeps running from the power-off release
					if (tick && (ms_ff == HOLD_REL_REC_MS - 14'h0001)) begin
						hold_rel_ff <= 1'b1;
						ms_ff       <= '0;
						state_ff    <= H_LINK;
					end
				end
				H_LINK: begin
					if (tick && (ms_ff == LINK_DET_MS - 14'h0001)) begin
						state_ff <= H_ON;
					end
				end
				H_ON: begin
					ms_ff <= '0;
					if (cmd_hw_off) begin
						hold_rel_ff <= 1'b0;
						state_ff    <= H_DN_HOLD;
					end else if (cmd_shutdown || cmd_full_reset) begin
						full_ff  <= cmd_full_reset;
						sd_ff    <= 1'b1;
						tmo_ff   <= 1'b0;
						state_ff <= H_SD_WAIT;
					end else if (cmd_warm_reset) begin
						rst_rel_ff <= 1'b0;
						state_ff   <= H_WRST;
					end else if (cmd_enter_l2) begin
						hold_rel_ff <= 1'b0;
						state_ff    <= H_L2;
					end
				end
				H_SD_WAIT: begin
					// Ack or timeout, whichever comes first
					if (bus.sd_ack || (tick && (ms_ff == SD_WAIT - 14'h0001))) begin
						tmo_ff      <= !bus.sd_ack;
						sd_ff       <= 1'b0;
						hold_rel_ff <= 1'b0;
						ms_ff       <= '0;
						state_ff    <= H_DN_HOLD;
					end
				end
				H_DN_HOLD: begin
					if (tick && (ms_ff == OFF1_REC_MS - 14'h0001)) begin
						rst_rel_ff <= 1'b0;
						ms_ff      <= '0;
						state_ff   <= H_DN_RST;
					end
				end
				H_DN_RST: begin
					if (tick && (ms_ff == OFF2_REC_MS - 14'h0001)) begin
						pwr_ff   <= 1'b0;
						ms_ff    <= '0;
						state_ff <= H_OFF_MIN;
					end
				end
				H_OFF_MIN: begin
					// Discharge time applies to every power-off
					if (tick && (ms_ff == OFF_HOLD - 14'h0001)) begin
						ms_ff    <= '0;
						pwr_ff   <= full_ff;
						full_ff  <= 1'b0;
						state_ff <= full_ff ? H_UP_RST : H_OFF;
					end
				end
				H_WRST: begin
					if (tick && (ms_ff == RST_HOLD_REC_MS - 14'h0001)) begin
						rst_rel_ff <= 1'b1;
						state_ff   <= H_ON;
					end
				end
				H_L2: begin
					if (cmd_exit_l2 || !bus.link_wake_n) begin
						hold_rel_ff <= 1'b1;
						ms_ff       <= '0;
						state_ff    <= H_LINK;
					end
				end
				default: begin
					state_ff <= H_OFF;
				end
			endcase
		end
	end

	// ********************************
	// Clock request and link-hold drive
	// ********************************
	// Value chosen on L2 entry is held for the whole stay
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			l2_req_ff  <= 1'b0;
			refclk_request_n_ff  <= 1'b0;
			hold_oe_ff <= 1'b0;
		end else begin
			hold_oe_ff <= hold_connected;
			if (state_ff != H_L2) begin
				l2_req_ff <= l2_refclk_request_n_on;
				refclk_request_n_ff <= want_refclk && (state_ff == H_ON);
			end else begin
				refclk_request_n_ff <= l2_req_ff;
			end
		end
	end

	// Separate dedicated pins for restart and link-hold
	assign bus.pwr_off_o      = pwr_ff;
	assign bus.pwr_off_oe     = 1'b1;
	assign bus.restart_o      = rst_rel_ff;
	assign bus.restart_oe     = 1'b1;
	assign bus.hold_o         = hold_rel_ff;
	assign bus.hold_oe        = hold_oe_ff;
	assign bus.host_refclk_request_n_oe = refclk_request_n_ff;
	assign bus.sd_req         = sd_ff;

	assign busy         = (state_ff != H_OFF) && (state_ff != H_ON) && (state_ff != H_L2);
	assign card_on      = (state_ff == H_ON);
	assign card_in_l2   = (state_ff == H_L2);
	assign sd_timed_out = tmo_ff;
endmodule

`default_nettype wire

// >>> modem_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none

module modem_ctrl_sva #(
	parameter int unsigned TICK_CYC  = 4,
	parameter int unsigned OFF_TICKS = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic card_power_off_n,
	input wire logic restart_n,
	input wire logic link_hold_n,
	input wire logic link_wake_n,
	input wire logic sd_req,
	input wire logic sd_ack
);
	// ****
	// Time spent with power on or off, and with link hold and restart low
	// ****
	int unsigned on_cnt_ff;
	int unsigned off_cnt_ff;
	int unsigned hold_lo_cnt_ff;
	int unsigned rst_lo_cnt_ff;

	function automatic int unsigned sat(input int unsigned v);
		return (v < 65535) ? v + 1 : v;
	endfunction

	// Off time starts saturated, so the first power-on after reset is legal
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			on_cnt_ff      <= 0;
			off_cnt_ff     <= 65535;
			hold_lo_cnt_ff <= 0;
			rst_lo_cnt_ff  <= 0;
		end else begin
			on_cnt_ff      <= card_power_off_n ? sat(on_cnt_ff) : 0;
			off_cnt_ff     <= card_power_off_n ? 0 : sat(off_cnt_ff);
			hold_lo_cnt_ff <= link_hold_n ? 0 : sat(hold_lo_cnt_ff);
			rst_lo_cnt_ff  <= restart_n ? 0 : sat(rst_lo_cnt_ff);
		end
	end

	// ****
	// Line ordering and spacing
	// ****
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Guard keeps a later warm reset release out of the start-up window
	restart_release_a: assert property ($rose(restart_n) && on_cnt_ff < 90 * TICK_CYC
		|-> on_cnt_ff >= 19 * TICK_CYC - 2 && on_cnt_ff <= 20 * TICK_CYC + 2)
		else $error("restart released outside start-up window");
	hold_release_a: assert property ($rose(link_hold_n) && on_cnt_ff < 120 * TICK_CYC
		|-> on_cnt_ff >= 99 * TICK_CYC - 2 && on_cnt_ff <= 100 * TICK_CYC + 2)
		else $error("link hold released outside start-up window");
	hold_last_a: assert property ($rose(link_hold_n) |-> restart_n && card_power_off_n)
		else $error("link hold released before other lines");
	restart_assert_a: assert property ($fell(restart_n) && !link_hold_n
		|-> hold_lo_cnt_ff >= 19 * TICK_CYC - 2)
		else $error("restart asserted too soon after link hold");
	power_drop_a: assert property ($fell(card_power_off_n)
		|-> !restart_n && rst_lo_cnt_ff >= 9 * TICK_CYC - 2)
		else $error("power off line dropped too soon after restart");
	off_hold_a: assert property ($rose(card_power_off_n)
		|-> off_cnt_ff >= (OFF_TICKS - 1) * TICK_CYC - 2)
		else $error("power off line released before discharge time");
	ack_cause_a: assert property ($rose(sd_ack) |-> sd_req ##[0:4] !link_hold_n)
		else $error("shutdown ack without request or no link hold");
	sd_req_run_a: assert property ($rose(sd_req) |-> card_power_off_n && restart_n)
		else $error("shutdown request while card not running");
	wake_in_l2_a: assert property ($fell(link_wake_n) |-> !link_hold_n && card_power_off_n)
		else $error("wake asserted outside low power link state");

	cover property ($rose(link_hold_n));
	cover property ($rose(sd_ack));
	cover property ($fell(link_wake_n));
	cover property ($rose(card_power_off_n) && off_cnt_ff < 65535);
endmodule

`default_nettype wire

// >>> modem_power_reset_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module modem_power_reset_sequencer_tb;
	import modem_seq_pkg::*;

	localparam int unsigned TCK = 4;

	// ****
	// Stimulus and observation
	// ****
	logic       core_clk       = 1'b0;
	logic       rst            = 1'b1;
	logic [6:0] cmd            = 7'h00; // on, sd, hw_off, warm, full, enter_l2, exit_l2
	logic       core_dump      = 1'b0;
	logic       wake_req       = 1'b0;
	logic       need_refclk    = 1'b0;
	logic       want_refclk    = 1'b0;
	logic       usb_present    = 1'b1;
	logic       pcie_present   = 1'b1;
	logic       l1_exit_req    = 1'b0;
	logic       l2_refclk_request_n_on   = 1'b0;
	logic       hold_connected = 1'b0;
	int         sd_cycles      = 0;
	logic       pu_on, card_in_reset, pcie_in_reset, init_done, link_up, pcie_en, usb_en;
	logic       in_l2, busy, card_on, card_in_l2, sd_timed_out;
	int         failures       = 0;
	int         samples_checked = 0;

	always #12.5 core_clk = ~core_clk;

	modem_ctrl_if modem_ctrl_if_inst ();

	modem_card_end #(.TICK_CYC(TCK), .INIT_TIME(14'h0020), .SAVE_TIME(14'h0004))
	modem_card_end_inst (.core_clk(core_clk), .rst(rst), .bus(modem_ctrl_if_inst),
		.core_dump(core_dump), .pcie_present(pcie_present), .usb_present(usb_present),
		.wake_req(wake_req), .need_refclk(need_refclk), .l1_exit_req(l1_exit_req),
		.internal_power_unit_on(pu_on), .card_in_reset(card_in_reset),
		.pcie_in_reset(pcie_in_reset), .init_done(init_done), .link_up(link_up),
		.pcie_en(pcie_en), .usb_en(usb_en), .in_l2(in_l2));

	modem_host_end #(.TICK_CYC(TCK), .SD_WAIT(14'h0010), .OFF_HOLD(14'h0010))
	modem_host_end_inst (.core_clk(core_clk), .rst(rst), .bus(modem_ctrl_if_inst),
		.cmd_power_on(cmd[0]), .cmd_shutdown(cmd[1]), .cmd_hw_off(cmd[2]),
		.cmd_warm_reset(cmd[3]), .cmd_full_reset(cmd[4]), .cmd_enter_l2(cmd[5]),
		.cmd_exit_l2(cmd[6]), .want_refclk(want_refclk), .l2_refclk_request_n_on(l2_refclk_request_n_on),
		.hold_connected(hold_connected), .busy(busy), .card_on(card_on), .card_in_l2(card_in_l2),
		.sd_timed_out(sd_timed_out));

	modem_ctrl_sva #(.TICK_CYC(TCK), .OFF_TICKS(16)) modem_ctrl_sva_inst (
		.core_clk(core_clk), .rst(rst),
		.card_power_off_n(modem_ctrl_if_inst.card_power_off_n),
		.restart_n(modem_ctrl_if_inst.restart_n), .link_hold_n(modem_ctrl_if_inst.link_hold_n),
		.link_wake_n(modem_ctrl_if_inst.link_wake_n), .sd_req(modem_ctrl_if_inst.sd_req),
		.sd_ack(modem_ctrl_if_inst.sd_ack));

	// Cycles with a shutdown request up; tasks compare before and after
	always @(posedge core_clk) begin
		if (modem_ctrl_if_inst.sd_req === 1'b1) begin
			sd_cycles <= sd_cycles + 1;
		end
	end

	// ****
	// Shared tasks
	// ****
	task automatic check(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	function automatic logic probe(input int sel);
		case (sel)
			0: return card_on;
			1: return busy;
			3: return in_l2;
			4: return modem_ctrl_if_inst.sd_ack;
			5: return modem_ctrl_if_inst.card_power_off_n;
			6: return card_in_reset;
			default: return init_done;
		endcase
	endfunction

	// Bounded wait; sampled 1 ns after the edge so the edge's updates have landed
	task automatic wait_for(input int sel, input logic val, input string what, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (probe(sel) !== val && n < 4000);
		check(what, val, probe(sel));
	endtask

	task automatic pulse(input int i);
		@(posedge core_clk);
		cmd[i] <= 1'b1;
		@(posedge core_clk);
		cmd[i] <= 1'b0;
	endtask

	task automatic final_report();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_power_on();
		int n;
		pulse(0);
		repeat (10 * TCK) @(posedge core_clk);
		#1;
		check("init_done early", 1'b0, init_done);
		check("card_in_reset", 1'b1, card_in_reset);
		check("pcie_in_reset", 1'b1, pcie_in_reset);
		wait_for(0, 1'b1, "card_on", n);
		check("power-up time", 1'b1, n >= 134 * TCK && n <= 136 * TCK + 4);
		check("power unit", 1'b1, pu_on);
		check("init_done", 1'b1, init_done);
		check("link_up", 1'b1, link_up);
		check("pcie_en", 1'b1, pcie_en);
		check("usb_en", 1'b0, usb_en);
		@(posedge core_clk);
		want_refclk <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check("host clock request", 1'b0, modem_ctrl_if_inst.refclk_request_n);
		// Host lets go as the card asks for an L1 exit, so only the card holds the line
		@(posedge core_clk);
		want_refclk <= 1'b0;
		l1_exit_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check("l1 exit clock request", 1'b0, modem_ctrl_if_inst.refclk_request_n);
		@(posedge core_clk);
		l1_exit_req <= 1'b0;
		$display("test power_on done");
	endtask

	// Device-started wake first, then host-started exit with the request held on
	task automatic t_l2();
		int n;
		for (int w = 0; w < 2; w++) begin
			pulse(5);
			wait_for(3, 1'b1, "in_l2", n);
			check("card_in_l2", 1'b1, card_in_l2);
			@(posedge core_clk);
			need_refclk <= 1'b1;
			repeat (3) @(posedge core_clk);
			#1;
			check("clock request frozen", w == 0, modem_ctrl_if_inst.refclk_request_n);
			if (w == 0) begin
				@(posedge core_clk);
				wake_req <= 1'b1;
			end else begin
				pulse(6);
			end
			wait_for(3, 1'b0, "l2 exit", n);
			@(posedge core_clk);
			wake_req <= 1'b0;
			wait_for(0, 1'b1, "card_on after wake", n);
			check("device clock request", 1'b0, modem_ctrl_if_inst.refclk_request_n);
			check("link_up after wake", 1'b1, link_up);
			@(posedge core_clk);
			need_refclk  <= 1'b0;
			l2_refclk_request_n_on <= 1'b1;
		end
		$display("test l2 done");
	endtask

	task automatic t_resets();
		int n;
		int sd0;
		pulse(3);
		wait_for(6, 1'b1, "warm reset", n);
		check("power kept", 1'b1, pu_on);
		check("link hold apart", 1'b1, modem_ctrl_if_inst.link_hold_n);
		wait_for(6, 1'b0, "warm release", n);
		check("init restarted", 1'b0, init_done);
		wait_for(7, 1'b1, "init_done", n);
		wait_for(0, 1'b1, "card_on", n);
		sd0 = sd_cycles;
		pulse(4);
		wait_for(5, 1'b0, "full reset off", n);
		check("full reset request", 1'b1, sd_cycles != sd0);
		wait_for(5, 1'b1, "full reset on", n);
		wait_for(0, 1'b1, "card_on", n);
		// USB alone attached: the card must open its USB port
		@(posedge core_clk);
		pcie_present <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check("usb_en alone", 1'b1, usb_en);
		check("pcie_en off", 1'b0, pcie_en);
		@(posedge core_clk);
		pcie_present <= 1'b1;
		$display("test resets done");
	endtask

	task automatic t_shutdown();
		int n;
		pulse(1);
		wait_for(4, 1'b1, "sd_ack", n);
		check("power unit off", 1'b0, pu_on);
		wait_for(1, 1'b0, "busy", n);
		check("card_on", 1'b0, card_on);
		check("sd_timed_out", 1'b0, sd_timed_out);
		check("power line", 1'b0, modem_ctrl_if_inst.card_power_off_n);
		$display("test shutdown done");
	endtask

	task automatic t_dump_hw_off();
		int n;
		int sd0;
		pulse(5);
		wait_for(3, 1'b1, "in_l2", n);
		@(posedge core_clk);
		core_dump <= 1'b1;
		wait_for(6, 1'b1, "core dump reset", n);
		@(posedge core_clk);
		core_dump <= 1'b0;
		pulse(6);
		wait_for(0, 1'b1, "card_on", n);
		sd0 = sd_cycles;
		pulse(2);
		wait_for(5, 1'b0, "hard off", n);
		check("no shutdown request", 1'b0, sd_cycles != sd0);
		repeat (2) @(posedge core_clk);
		#1;
		check("power unit off", 1'b0, pu_on);
		$display("test dump_hw_off done");
	endtask

	// Watchdog: the whole run needs well under this many cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		failures++;
		final_report();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		// Link-hold unconnected at first: the host must leave both lines alone
		repeat (2) @(posedge core_clk);
		#1;
		check("floating link hold", 1'b1, modem_ctrl_if_inst.link_hold_n);
		check("floating clock request", 1'b1, modem_ctrl_if_inst.refclk_request_n);
		@(posedge core_clk);
		hold_connected <= 1'b1;
		t_power_on();
		t_l2();
		t_resets();
		t_shutdown();
		t_power_on();
		t_dump_hw_off();
		final_report();
	end
endmodule

`default_nettype wire
